// *** core/bpd_cfg.svh ***
// Constants of the backplane data transfer slave
`ifndef BPD_CFG_SVH
`define BPD_CFG_SVH

// ------------------------------------------------
// Clock and bus timer
// ------------------------------------------------
`define BPD_CLK_NS 50
`define BPD_BT_TIME_NS 64000
`define BPD_BT_CYCLES ((`BPD_BT_TIME_NS) / (`BPD_CLK_NS))
`define BPD_BT_MIN 2

// ------------------------------------------------
// Address spaces and block limit
// ------------------------------------------------
`define BPD_MASK_A16 32'h0000FFFE
`define BPD_MASK_A24 32'h00FFFFFE
`define BPD_MASK_A32 32'hFFFFFFFE
`define BPD_BLOCK_MAX 9'h100

// ------------------------------------------------
// Beat sizes and reset values
// ------------------------------------------------
`define BPD_BEAT1 3'h1
`define BPD_BEAT2 3'h2
`define BPD_BEAT4 3'h4
`define BPD_WORD_RST 32'h00000000
`define BPD_LANE_RST 4'h0

`endif

// *** core/bpd_pkg.sv ***
// Types of the backplane data transfer slave
package bpd_pkg;

   typedef enum logic [1:0] {SPACE_A16, SPACE_A24, SPACE_A32} bpd_space_type;

   typedef enum logic [1:0] {PORT_D08O, PORT_D08EO, PORT_D16, PORT_D32} bpd_port_type;

   typedef enum logic [2:0] {ST_IDLE, ST_IGNORE, ST_ADDR, ST_MEM, ST_ACK} bpd_state_type;

endpackage

// *** core/bpd_lanes.sv ***
// Byte lane steering between the backplane and a right-justified word
`include "bpd_cfg.svh"
module bpd_lanes
(
   input wire logic ds0_n,
   input wire logic ds1_n,
   input wire logic lword_n,
   input wire logic a01,
   input wire bpd_pkg::bpd_port_type port,
   input wire logic [31:0] rd_word,
   input wire logic [31:0] bus_din,
   output logic legal,
   output logic [2:0] size,
   output logic [1:0] off,
   output logic [3:0] lane_oe,
   output logic [31:0] rd_lanes,
   output logic [31:0] wr_word
);
   import bpd_pkg::*;

   // ------------------------------------------------
   // Beat shape
   // ------------------------------------------------
   wire logic odd_b = !ds0_n && ds1_n && lword_n;
   wire logic even_b = ds0_n && !ds1_n && lword_n;
   wire logic dbl = !ds0_n && !ds1_n && lword_n;
   wire logic quad = !ds0_n && !ds1_n && !lword_n && !a01;
   wire logic wide16 = port == PORT_D16 || port == PORT_D32;

   assign legal = odd_b
      || (even_b && port != PORT_D08O)
      || (dbl && wide16)
      || (quad && port == PORT_D32);
   assign size = quad ? `BPD_BEAT4 : (dbl ? `BPD_BEAT2 : `BPD_BEAT1);
   assign off = {a01, odd_b};

   // ------------------------------------------------
   // Lane selection
   // ------------------------------------------------
   assign lane_oe = quad ? 4'hF : (dbl ? 4'h3 : (even_b ? 4'h2 : (odd_b ? 4'h1 : 4'h0)));
   assign rd_lanes = quad ? rd_word :
      dbl ? {16'h0000, rd_word[15:0]} :
      even_b ? {16'h0000, rd_word[7:0], 8'h00} :
      {24'h000000, rd_word[7:0]};
   assign wr_word = quad ? bus_din :
      dbl ? {16'h0000, bus_din[15:0]} :
      even_b ? {24'h000000, bus_din[15:8]} :
      {24'h000000, bus_din[7:0]};

endmodule // bpd_lanes

// *** core/bpd_bus_timer.sv ***
// Bus timer that ends stalled transfers with a bus error
`include "bpd_cfg.svh"
module bpd_bus_timer
#(
   parameter int TIMEOUT_CYC = `BPD_BT_CYCLES
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic timer_en,
   input wire logic ds_act,
   input wire logic dtack_n_i,
   output logic berr_oe,
   output logic timeout
);
   import bpd_pkg::*;

   localparam int CW = $clog2(TIMEOUT_CYC + 1);

   if (TIMEOUT_CYC < `BPD_BT_MIN)
   begin : g_bad
      $error("bus timer timeout too short");
   end

   logic [CW-1:0] count;
   logic fired;

   // ------------------------------------------------
   // Transfer duration
   // ------------------------------------------------
   wire logic waiting = timer_en && ds_act && dtack_n_i && !fired;
   wire logic expire = waiting && count == CW'(TIMEOUT_CYC - 1);

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         count <= '0;
      else if (!ds_act)
         count <= '0;
      else if (waiting)
         count <= count + 1'b1;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         fired <= 1'b0;
      else if (!ds_act)
         fired <= 1'b0;
      else if (expire)
         fired <= 1'b1;
   end

   assign berr_oe = fired;
   assign timeout = expire;

endmodule // bpd_bus_timer

// *** core/bpd_slave.sv ***
// Backplane data transfer slave with single, block and address-only cycles
//
// What this block does
// - A16, A24 and A32 decoding compares address bits up to 15, 23 or 31.
// - An address-only cycle is never acknowledged and ends when the address strobe is released.
// - A block moves 1 to 256 bytes inside one address strobe.
// - Each block beat moves 1, 2 or 4 bytes until the block is done.
// - A block read latches one address and modifier and steps up after each beat.
// - A block write stores each beat at the next higher address.
// - A bus timer measures every transfer and ends one that takes too long.
// - An odd-byte-only slave uses the low lane D00-D07 alone.
// - A two-lane byte slave moves a byte on D00-D07 or D08-D15.
// - A 16-bit slave moves 16-bit items on D00-D15 at once.
// - A 32-bit slave moves 32-bit items on D00-D31 at once.
// - Six modifier bits travel with the address and steer the decode.
`include "bpd_cfg.svh"
module bpd_slave
#(
   parameter int TIMEOUT_CYC = `BPD_BT_CYCLES
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic as_n,
   input wire logic ds0_n,
   input wire logic ds1_n,
   input wire logic lword_n,
   input wire logic write_n,
   input wire logic [31:1] addr,
   input wire logic [5:0] am,
   input wire logic [31:0] data_i,
   output logic [31:0] data_o,
   output logic [3:0] data_oe,
   input wire logic dtack_n_i,
   output logic dtack_n_o,
   output logic dtack_oe,
   input wire logic berr_n_i,
   output logic berr_n_o,
   output logic berr_oe,
   input wire logic timer_en,
   input wire bpd_pkg::bpd_space_type cfg_space,
   input wire bpd_pkg::bpd_port_type cfg_port,
   input wire logic [31:0] cfg_base,
   input wire logic [31:0] cfg_mask,
   input wire logic [5:0] cfg_am_single,
   input wire logic [5:0] cfg_am_block,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [2:0] mem_size,
   output logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ack,
   output logic selected,
   output logic bus_timeout
);
   import bpd_pkg::*;

   // ------------------------------------------------
   // Decode helpers
   // ------------------------------------------------
   function automatic logic [31:0] space_mask(input bpd_space_type sp);
      case (sp)
         SPACE_A16: space_mask = `BPD_MASK_A16;
         SPACE_A24: space_mask = `BPD_MASK_A24;
         SPACE_A32: space_mask = `BPD_MASK_A32;
         default: space_mask = `BPD_MASK_A16;
      endcase
   endfunction

   bpd_state_type state;
   bpd_state_type next_state;
   logic as_prev;
   logic blk;
   logic [31:0] cur_addr;
   logic [8:0] bytes_done;

   wire logic [31:0] smask = space_mask(cfg_space);
   wire logic [31:0] bus_addr = {addr, 1'b0} & smask;
   wire logic as_fall = !as_n && as_prev;
   wire logic am_single = am == cfg_am_single;
   wire logic am_block = am == cfg_am_block;
   wire logic addr_hit = ((bus_addr ^ cfg_base) & cfg_mask & smask) == 32'h00000000;
   wire logic hit = addr_hit && (am_single || am_block);
   wire logic ds_act = !ds0_n || !ds1_n;
   wire logic ds_idle = ds0_n && ds1_n;
   wire logic berr_seen = !berr_n_i;

   // ------------------------------------------------
   // State decode
   // ------------------------------------------------
   wire logic in_idle = state == ST_IDLE;
   wire logic in_addr = state == ST_ADDR;
   wire logic in_mem = state == ST_MEM;
   wire logic in_ack = state == ST_ACK;

   // ------------------------------------------------
   // Parameter checks
   // ------------------------------------------------
   if (TIMEOUT_CYC < `BPD_BT_MIN)
   begin : g_bad_timeout
      $error("timeout below the timer minimum");
   end

   // ------------------------------------------------
   // Lane steering
   // ------------------------------------------------
   logic legal;
   logic [2:0] size;
   logic [1:0] off;
   logic [3:0] lane_oe;
   logic [31:0] rd_lanes;
   logic [31:0] wr_word;

   bpd_lanes u_lanes
   (
      .ds0_n(ds0_n),
      .ds1_n(ds1_n),
      .lword_n(lword_n),
      .a01(cur_addr[1]),
      .port(cfg_port),
      .rd_word(mem_rdata),
      .bus_din(data_i),
      .legal(legal),
      .size(size),
      .off(off),
      .lane_oe(lane_oe),
      .rd_lanes(rd_lanes),
      .wr_word(wr_word)
   );

   // ------------------------------------------------
   // Bus timer
   // ------------------------------------------------
   bpd_bus_timer #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_timer
   (
      .core_clk(core_clk),
      .rst(rst),
      .timer_en(timer_en),
      .ds_act(ds_act),
      .dtack_n_i(dtack_n_i),
      .berr_oe(berr_oe),
      .timeout(bus_timeout)
   );

   assign berr_n_o = 1'b0;

   // ------------------------------------------------
   // Beat address and block accounting
   // ------------------------------------------------
   wire logic [31:0] beat_addr = blk ? cur_addr : {cur_addr[31:2], off};
   wire logic [9:0] bytes_after = {1'b0, bytes_done} + {7'h00, size};
   wire logic over = blk && (bytes_after > {1'b0, `BPD_BLOCK_MAX});
   wire logic [31:0] step_mask = smask | 32'h00000001;
   wire logic [31:0] step_sum = cur_addr + {29'h00000000, size};
   wire logic [31:0] step_addr = step_sum & step_mask;
   wire logic beat_ok = legal && !over && !berr_seen;

   // ------------------------------------------------
   // Cycle sequencing
   // ------------------------------------------------
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
         begin
            if (as_fall)
               next_state = hit ? ST_ADDR : ST_IGNORE;
         end
         ST_IGNORE:
         begin
            if (as_n)
               next_state = ST_IDLE;
         end
         ST_ADDR:
         begin
            if (as_n)
               next_state = ST_IDLE;
            else if (ds_act)
               next_state = beat_ok ? ST_MEM : ST_IGNORE;
         end
         ST_MEM:
         begin
            if (berr_seen)
               next_state = ST_IGNORE;
            else if (mem_ack)
               next_state = ST_ACK;
         end
         ST_ACK:
         begin
            if (ds_idle)
               next_state = ST_ADDR;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         as_prev <= 1'b1;
      else
         as_prev <= as_n;
   end

   // ------------------------------------------------
   // Latched address, modifier and block count
   // ------------------------------------------------
   wire logic take_addr = in_idle && as_fall && hit;
   wire logic beat_done = in_mem && mem_ack && !berr_seen;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         blk <= 1'b0;
         cur_addr <= `BPD_WORD_RST;
      end
      else if (take_addr)
      begin
         blk <= am_block;
         cur_addr <= bus_addr;
      end
      else if (beat_done && blk)
         cur_addr <= step_addr;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         bytes_done <= 9'h000;
      else if (take_addr)
         bytes_done <= 9'h000;
      else if (beat_done)
         bytes_done <= bytes_after[8:0];
   end

   // ------------------------------------------------
   // Local memory request
   // ------------------------------------------------
   wire logic start_beat = in_addr && !as_n && ds_act && beat_ok;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         mem_we <= 1'b0;
         mem_addr <= `BPD_WORD_RST;
         mem_size <= `BPD_BEAT1;
         mem_wdata <= `BPD_WORD_RST;
      end
      else if (start_beat)
      begin
         mem_we <= !write_n;
         mem_addr <= beat_addr;
         mem_size <= size;
         mem_wdata <= wr_word;
      end
   end

   assign mem_req = in_mem;

   // ------------------------------------------------
   // Read data onto the lanes
   // ------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         data_o <= `BPD_WORD_RST;
         data_oe <= `BPD_LANE_RST;
      end
      else if (beat_done)
      begin
         data_o <= rd_lanes;
         data_oe <= mem_we ? `BPD_LANE_RST : lane_oe;
      end
      else if (!in_ack || ds_idle)
         data_oe <= `BPD_LANE_RST;
   end

   // ------------------------------------------------
   // Acknowledge and status
   // ------------------------------------------------
   assign dtack_n_o = 1'b0;
   assign dtack_oe = in_ack;
   assign selected = in_addr || in_mem || in_ack;

endmodule // bpd_slave

// *** tb/bpd_slave_chk.sv ***
// Concurrent checks on the backplane slave ports
module bpd_slave_chk
#(
   parameter int TIMEOUT_CYC = 8
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic as_n,
   input wire logic ds0_n,
   input wire logic ds1_n,
   input wire logic dtack_n_i,
   input wire logic berr_n_i,
   input wire logic timer_en,
   input wire logic dtack_oe,
   input wire logic [3:0] data_oe,
   input wire logic berr_oe,
   input wire logic mem_req,
   input wire logic mem_ack,
   input wire logic selected,
   input wire logic bus_timeout
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------
   // Checks
   // ----------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   int stall_cnt;
   wire ds_idle = ds0_n && ds1_n;
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
         stall_cnt <= 0;
      else if (ds_idle)
         stall_cnt <= 0;
      else if (timer_en && dtack_n_i)
         stall_cnt <= stall_cnt + 1;
   sequence s_as_fall;
      as_n ##1 !as_n;
   endsequence
   sequence s_release;
      ds_idle ##1 ds_idle;
   endsequence
   a_addr_only_quiet: assert property (s_as_fall ##1 (!as_n && ds_idle) [*4] |-> !dtack_oe)
      else $error("address-only cycle acknowledged");
   a_release_drop: assert property (s_release |-> !dtack_oe && data_oe == 4'h0)
      else $error("drive kept after strobes released");
   a_ack_after_mem: assert property ($rose(dtack_oe) |-> $past(mem_ack))
      else $error("acknowledge without local completion");
   a_mem_to_ack: assert property (mem_req && mem_ack && berr_n_i |=> dtack_oe)
      else $error("local completion not acknowledged");
   a_req_held: assert property (mem_req && !mem_ack && berr_n_i |=> mem_req)
      else $error("local request dropped early");
   a_miss_quiet: assert property (!selected |-> !dtack_oe && data_oe == 4'h0)
      else $error("drive while not selected");
   a_timeout_berr: assert property (bus_timeout |=> berr_oe)
      else $error("timeout without bus error");
   a_timer_len: assert property (bus_timeout |-> stall_cnt >= TIMEOUT_CYC - 1 && stall_cnt <= TIMEOUT_CYC + 1)
      else $error("timeout at wrong count");
endmodule // bpd_slave_chk

bind bpd_slave bpd_slave_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.core_clk(core_clk), .rst(rst), .as_n(as_n),
   .ds0_n(ds0_n), .ds1_n(ds1_n), .dtack_n_i(dtack_n_i), .berr_n_i(berr_n_i), .timer_en(timer_en),
   .dtack_oe(dtack_oe), .data_oe(data_oe), .berr_oe(berr_oe), .mem_req(mem_req), .mem_ack(mem_ack),
   .selected(selected), .bus_timeout(bus_timeout));

// *** tb/bpd_mem_model.sv ***
// Local storage model behind the slave
module bpd_mem_model
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [2:0] mem_size,
   input wire logic [31:0] mem_wdata,
   output logic [31:0] mem_rdata,
   output logic mem_ack
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:511];
   logic [31:0] rd;
   logic [1:0] cnt;
   wire [7:0] a = mem_addr[7:0];
   wire take = mem_req && !mem_ack;
   always_comb
   begin
      rd = 32'h0;
      for (int i = 0; i < mem_size; i++)
         rd = {rd[23:0], mem[a + i]};
   end
   assign mem_rdata = mem_ack ? rd : ~rd;
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
      begin
         mem_ack <= 1'h0;
         cnt <= 2'h0;
      end
      else if (take && cnt < {slow, 1'h0})
         cnt <= cnt + 2'h1;
      else
      begin
         mem_ack <= take;
         cnt <= 2'h0;
         if (take && mem_we)
            for (int i = 0; i < mem_size; i++)
               mem[a + i] <= mem_wdata[8 * (mem_size - 1 - i) +: 8];
      end
endmodule // bpd_mem_model

// *** tb/testbench.sv ***
// Self-checking bench of the backplane slave
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import bpd_pkg::*;
   localparam logic [31:0] BASE = 32'h00120000;
   logic core_clk = 1'h0, rst = 1'h1, as_n = 1'h1, ds0_n = 1'h1, ds1_n = 1'h1;
   logic lword_n = 1'h1, write_n = 1'h1, slow = 1'h0, tmr = 1'h1;
   logic [31:1] addr = 31'h0;
   logic [5:0] am = 6'h0;
   logic [31:0] data_i = 32'h0;
   bpd_port_type port = PORT_D32;
   bpd_space_type space = SPACE_A24;
   logic [31:0] data_o, mem_addr, mem_wdata, mem_rdata;
   logic [3:0] data_oe;
   logic [2:0] mem_size;
   logic dtack_oe, berr_oe, mem_req, mem_we, mem_ack, selected, bus_timeout;
   int n_mismatch = 0, tests_run = 0, cycles = 0;
   wire dtack_n_i = ~dtack_oe;
   wire berr_n_i = ~berr_oe;
   bpd_slave #(.TIMEOUT_CYC(12)) u_dut (.core_clk(core_clk), .rst(rst), .as_n(as_n), .ds0_n(ds0_n),
      .ds1_n(ds1_n), .lword_n(lword_n), .write_n(write_n), .addr(addr), .am(am), .data_i(data_i),
      .data_o(data_o), .data_oe(data_oe), .dtack_n_i(dtack_n_i), .dtack_n_o(), .dtack_oe(dtack_oe),
      .berr_n_i(berr_n_i), .berr_n_o(), .berr_oe(berr_oe), .timer_en(tmr), .cfg_space(space),
      .cfg_port(port), .cfg_base(BASE), .cfg_mask(32'h00FF0000), .cfg_am_single(6'h39),
      .cfg_am_block(6'h3B), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
      .selected(selected), .bus_timeout(bus_timeout));
   bpd_mem_model u_mem (.core_clk(core_clk), .rst(rst), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack));
   always #25 core_clk = ~core_clk;
   // ----------------
   // Tasks
   // ----------------
   task automatic complete_run;
      if (n_mismatch == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         complete_run;
      end
   end
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_k(input logic [1:0] got, input logic [1:0] exp);
      chk_val({30'h0, got}, {30'h0, exp});
   endtask
   task automatic tick;
      @(posedge core_clk);
      #5;
   endtask
   task automatic as_go(input logic [31:0] a, input logic [5:0] m);
      tick;
      addr = a[31:1];
      am = m;
      tick;
      as_n = 1'h0;
   endtask
   task automatic as_stop;
      tick;
      as_n = 1'h1;
      tick;
   endtask
   task automatic beat(input logic w, input logic [2:0] sel, input logic [31:0] d,
      output logic [31:0] q, output logic [3:0] e, output logic [1:0] k);
      tick;
      {lword_n, ds1_n, ds0_n} = sel;
      write_n = !w;
      data_i = d;
      for (int i = 0; i < 40 && dtack_oe !== 1'h1 && berr_oe !== 1'h1; i++)
         tick;
      q = data_o;
      e = data_oe;
      k = {berr_oe, dtack_oe};
      tick;
      {lword_n, ds1_n, ds0_n} = 3'h7;
      data_i = ~d;
      for (int i = 0; i < 40 && (dtack_oe !== 1'h0 || berr_oe !== 1'h0); i++)
         tick;
   endtask
   // ----------------
   // Scenarios
   // ----------------
   task automatic t_single;
      logic [31:0] q;
      logic [3:0] e;
      logic [1:0] k;
      as_go(BASE, 6'h39);
      beat(1'h1, 3'h0, 32'hA1B2C3D4, q, e, k);
      beat(1'h0, 3'h0, 32'h0, q, e, k);
      chk_val(q, 32'hA1B2C3D4);
      chk_val({28'h0, e}, 32'hF);
      as_stop;
      as_go(BASE + 32'h10, 6'h39);
      beat(1'h1, 3'h5, 32'h7700, q, e, k);
      beat(1'h1, 3'h6, 32'h88, q, e, k);
      beat(1'h0, 3'h4, 32'h0, q, e, k);
      chk_val(q & 32'hFFFF, 32'h7788);
      beat(1'h0, 3'h5, 32'h0, q, e, k);
      chk_val({q[15:8], e}, 32'h772);
      as_stop;
      as_go(BASE | 32'h40000000, 6'h39);
      beat(1'h0, 3'h0, 32'h0, q, e, k);
      chk_val(q, 32'hA1B2C3D4);
      as_stop;
      space = SPACE_A32;
      as_go(BASE | 32'h40000010, 6'h39);
      beat(1'h0, 3'h4, 32'h0, q, e, k);
      chk_val(mem_addr, 32'h40120010);
      chk_val(q & 32'hFFFF, 32'h7788);
      as_stop;
      space = SPACE_A16;
      as_go(32'h00FF0010, 6'h39);
      beat(1'h0, 3'h4, 32'h0, q, e, k);
      chk_val(mem_addr, 32'h00000010);
      as_stop;
      space = SPACE_A24;
   endtask
   task automatic t_block;
      logic [31:0] q;
      logic [3:0] e;
      logic [1:0] k;
      logic [31:0] v [3] = '{32'h11223344, 32'h55667788, 32'h9AAB};
      logic [2:0] s [3] = '{3'h0, 3'h0, 3'h4};
      as_go(BASE + 32'h20, 6'h3B);
      for (int i = 0; i < 3; i++)
         beat(1'h1, s[i], v[i], q, e, k);
      as_stop;
      as_go(BASE + 32'h24, 6'h39);
      beat(1'h0, 3'h0, 32'h0, q, e, k);
      chk_val(q, v[1]);
      as_stop;
      as_go(BASE + 32'h30, 6'h3B);
      beat(1'h1, 3'h6, 32'h5A, q, e, k);
      beat(1'h1, 3'h6, 32'hC3, q, e, k);
      as_stop;
      as_go(BASE + 32'h30, 6'h39);
      beat(1'h0, 3'h4, 32'h0, q, e, k);
      chk_val(q & 32'hFFFF, 32'h5AC3);
      as_stop;
      slow = 1'h1;
      as_go(BASE + 32'h20, 6'h3B);
      for (int i = 0; i < 3; i++)
      begin
         beat(1'h0, s[i], 32'h0, q, e, k);
         chk_val(q & (i == 2 ? 32'hFFFF : 32'hFFFFFFFF), v[i]);
      end
      as_stop;
      slow = 1'h0;
   endtask
   task automatic t_limit_miss;
      logic [31:0] q;
      logic [3:0] e;
      logic [1:0] k;
      logic [31:0] acks;
      acks = 0;
      as_go(BASE + 32'h40, 6'h3B);
      for (int i = 0; i < 65; i++)
      begin
         beat(1'h1, 3'h0, i, q, e, k);
         acks += k[0];
      end
      chk_val(acks, 32'd64);
      chk_k(k, 2'h2);
      as_stop;
      as_go(BASE, 6'h0D);
      beat(1'h0, 3'h0, 32'h0, q, e, k);
      chk_k(k, 2'h2);
      as_stop;
      as_go(BASE + 32'h50, 6'h39);
      repeat (6)
         tick;
      chk_k({selected, dtack_oe}, 2'h2);
      as_stop;
      port = PORT_D16;
      as_go(BASE, 6'h39);
      beat(1'h0, 3'h0, 32'h0, q, e, k);
      chk_k(k, 2'h2);
      as_stop;
      port = PORT_D08EO;
      as_go(BASE + 32'h10, 6'h39);
      beat(1'h0, 3'h5, 32'h0, q, e, k);
      chk_k(k, 2'h1);
      chk_val({28'h0, e}, 32'h2);
      as_stop;
      port = PORT_D08O;
      as_go(BASE + 32'h11, 6'h39);
      beat(1'h0, 3'h6, 32'h0, q, e, k);
      chk_val({28'h0, e}, 32'h1);
      as_stop;
      tmr = 1'h0;
      as_go(BASE + 32'h10, 6'h39);
      beat(1'h0, 3'h5, 32'h0, q, e, k);
      chk_k(k, 2'h0);
      as_stop;
      tmr = 1'h1;
   endtask
   initial
   begin
      repeat (16)
         @(posedge core_clk);
      #5 rst = 1'h0;
      t_single;
      t_block;
      t_limit_miss;
      complete_run;
   end
endmodule // testbench
